// ==== core/reg_map_consts.vh ====
`ifndef REG_MAP_CONSTS_VH
`define REG_MAP_CONSTS_VH

// Register offsets on the four address lines.
`define OFF_BUS_DEVICE_ID 4'h0
`define OFF_CTRL_CONTROL  4'h1
`define OFF_COMMAND_CODE  4'h2
`define OFF_XFER_MODE     4'h3
`define OFF_INT_SENSE     4'h4
`define OFF_PHASE_DIAG    4'h5
`define OFF_CTRL_STATE    4'h6
`define OFF_ERROR_FLAGS   4'h7
`define OFF_PHASE_CONTROL 4'h8
`define OFF_EXT_COUNT     4'h9
`define OFF_DATA_FIFO     4'hA
`define OFF_TEMP_BYTE     4'hB
`define OFF_COUNT_HIGH    4'hC
`define OFF_COUNT_MID     4'hD
`define OFF_COUNT_LOW     4'hE
`define OFF_EXT_BUFFER    4'hF

// Field positions.
`define INT_EN_BIT        0
`define XFER_EXT_BIT      0
`define IS_RESET_BIT      0
`define IS_SERVICE_BIT    3
`define IS_CMD_DONE_BIT   4
`define PC_RST_MASK_BIT   4
`define PC_ATN_EN_BIT     5
`define PC_ARB_EN_BIT     6
`define PC_ZERO_BIT       3
`define ERR_ZERO_MASK     8'hCF

// Reset values and sizes.
`define BYTE_ZERO         8'h00
`define NIB_ZERO          4'h0
`define ID_ZERO           3'h0
`define COUNT_ZERO        28'h0000000
`define COUNT_ONE         28'h0000001
`define FIFO_DEPTH        8
`define FIFO_AW           3
`define PTR_ZERO          3'h0
`define PTR_ONE           3'h1
`define LVL_ZERO          4'h0
`define LVL_ONE           4'h1
`define LVL_FULL          4'h8

`endif

// ==== core/reg_map.v ====
// Functional notes
// - Sixteen byte registers, each picked by a four-bit address while select is low.
// - Address map runs device ID, control, command, mode, interrupt_sense_reset, phase, status, etc.
// - Address 5 reads phase sense and writes diagnostic control.
// - Odd parity out for each host byte; parity pin floats while device drives data.
// - Bus reset raises the unmaskable reset interrupt regardless of mask bit.
// - Bus reset raises general interrupt only when phase control bit 4 is 0.
// - With phase control bit 6 set, lost arbitration raises command complete.
// - Status bit 7 shows initiator, bit 6 target; both zero means lost arbitration.
// - With phase control bit 5 set, attention as target raises service required.
// - Service required clears by writing 1 to bit 3 or on leaving target role.
// - Mode bit 0 set makes counter 28 bits, top nibble via extended count 7:4.
// - Mode bit 0 clear keeps 24 bits; extended upper nibble reads zero.
// - Writes to read-only registers are ignored.
// - Fixed zero bits read zero; unused bits accept any written value.
// - Host may write 0 or 1 into unassigned bits; device tolerates both.
// - Data register is an eight-byte FIFO at a single address.
// - Temporary reads give last byte from bus; written byte goes to the bus.
// - Count high, middle and low hold bits 23:16, 15:8, 7:0, all read/write.
// - Reset works asynchronously, clearing every register except the strobe copies and host parity, which preset to 1.
// - General interrupt is active high, maskable, held until its cause clears.
`timescale 1ns/1ps
`include "reg_map_consts.vh"
`default_nettype none

module reg_map (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        cs_n_i,
  input  wire        rd_n_i,
  input  wire        wt_n_i,
  input  wire [3:0]  addr_i,
  input  wire [7:0]  data_i,
  output reg  [7:0]  data_o,
  output wire        data_oe_o,
  output wire        data_par_o,
  output reg         host_parity_out_o,
  output wire        host_parity_oe_o,
  input  wire        bus_reset_det_i,
  input  wire        arb_lost_i,
  input  wire        atn_det_i,
  input  wire        initiator_i,
  input  wire        target_i,
  input  wire [7:0]  int_event_i,
  input  wire [7:0]  phase_sense_i,
  input  wire [2:0]  ctrl_status_i,
  input  wire [7:0]  error_flags_i,
  input  wire [3:0]  mod_count_i,
  input  wire        temp_load_i,
  input  wire [7:0]  temp_in_i,
  output reg  [7:0]  temp_out_o,
  input  wire        fifo_push_i,
  input  wire [7:0]  fifo_data_i,
  input  wire        fifo_pop_i,
  output wire [7:0]  fifo_data_o,
  output wire        fifo_full_o,
  output wire        fifo_empty_o,
  input  wire        tc_dec_i,
  output wire        tc_zero_o,
  output wire [27:0] count_o,
  output reg  [7:0]  controller_control_o,
  output reg  [7:0]  command_code_o,
  output reg         cmd_issue_o,
  output reg  [7:0]  transfer_mode_o,
  output reg  [7:0]  phase_control_o,
  output reg  [7:0]  diag_control_o,
  output reg  [2:0]  bus_device_id_o,
  input  wire [7:0]  ext_buf_i,
  output reg  [7:0]  ext_buf_o,
  output reg         ext_buf_wr_o,
  output reg         bus_reset_irq_o,
  output reg         general_irq_o
);

  // Address match used by both the write and the read side.
  function sel;
    input [3:0] a;
    input [3:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  // Previous-cycle copies of the host strobes, address and data.
  reg        cs_n_r;
  reg        rd_n_r;
  reg        wt_n_r;
  reg  [3:0] addr_r;
  reg  [7:0] wdata_r;

  // Interrupt sense flags and the full 28-bit transfer counter.
  reg  [7:0]  interrupt_sense_reset_r;
  reg  [7:0]  interrupt_sense_reset_nxt;
  reg  [27:0] cnt_r;
  reg  [7:0]  temp_in_r;
  reg         target_r;

  // FIFO storage and pointers.
  reg  [7:0]            mem_r [0:`FIFO_DEPTH-1];
  reg  [`FIFO_AW-1:0]   wr_ptr_r;
  reg  [`FIFO_AW-1:0]   rd_ptr_r;
  reg  [`FIFO_AW:0]     level_r;

  wire [7:0] rdata_nxt;
  reg  [7:0] rd_mux;

  // A write is taken when the write strobe rises after a selected low phase.
  wire wr_take = ~cs_n_r & ~wt_n_r & wt_n_i;
  // A read completes on the rising edge of the read strobe.
  wire rd_done = ~cs_n_r & ~rd_n_r & rd_n_i;
  wire rd_act  = ~cs_n_i & ~rd_n_i;

  wire ext_mode = transfer_mode_o[`XFER_EXT_BIT];
  wire [27:0] eff_cnt = ext_mode ? cnt_r : {`NIB_ZERO, cnt_r[23:0]};

  // Sampling of the host strobes; the inputs are already clock-synchronous.
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_n_r  <= 1'b1;
      rd_n_r  <= 1'b1;
      wt_n_r  <= 1'b1;
      addr_r  <= `NIB_ZERO;
      wdata_r <= `BYTE_ZERO;
    end
    else
    begin
      cs_n_r  <= cs_n_i;
      rd_n_r  <= rd_n_i;
      wt_n_r  <= wt_n_i;
      addr_r  <= addr_i;
      wdata_r <= data_i;
    end
  end

  // Host-writable configuration registers.  Status and error addresses have
  // no write arm at all, so a write there changes nothing.
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_device_id_o      <= `ID_ZERO;
      controller_control_o <= `BYTE_ZERO;
      command_code_o       <= `BYTE_ZERO;
      cmd_issue_o          <= 1'b0;
      transfer_mode_o      <= `BYTE_ZERO;
      phase_control_o      <= `BYTE_ZERO;
      diag_control_o       <= `BYTE_ZERO;
      temp_out_o           <= `BYTE_ZERO;
      ext_buf_o            <= `BYTE_ZERO;
      ext_buf_wr_o         <= 1'b0;
    end
    else
    begin
      cmd_issue_o  <= 1'b0;
      ext_buf_wr_o <= 1'b0;
      if (wr_take)
      begin
        case (addr_r)
          `OFF_BUS_DEVICE_ID: bus_device_id_o <= wdata_r[2:0];
          `OFF_CTRL_CONTROL:  controller_control_o <= wdata_r;
          `OFF_COMMAND_CODE:
          begin
            command_code_o <= wdata_r;
            cmd_issue_o    <= 1'b1;
          end
          `OFF_XFER_MODE:     transfer_mode_o <= wdata_r;
          `OFF_PHASE_DIAG:    diag_control_o <= wdata_r;
          `OFF_PHASE_CONTROL: phase_control_o <= wdata_r;
          `OFF_TEMP_BYTE:     temp_out_o <= wdata_r;
          `OFF_EXT_BUFFER:
          begin
            ext_buf_o    <= wdata_r;
            ext_buf_wr_o <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Byte captured from the bus for the temporary register.
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      temp_in_r <= `BYTE_ZERO;
    else if (temp_load_i)
      temp_in_r <= temp_in_i;
  end

  // Transfer counter: host byte writes win over a decrement in the same
  // cycle, which is harmless because the host must not load it mid-transfer.
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_r <= `COUNT_ZERO;
    else if (wr_take && sel(addr_r, `OFF_COUNT_HIGH))
      cnt_r[23:16] <= wdata_r;
    else if (wr_take && sel(addr_r, `OFF_COUNT_MID))
      cnt_r[15:8] <= wdata_r;
    else if (wr_take && sel(addr_r, `OFF_COUNT_LOW))
      cnt_r[7:0] <= wdata_r;
    else if (wr_take && sel(addr_r, `OFF_EXT_COUNT))
      cnt_r[27:24] <= wdata_r[7:4];
    else if (tc_dec_i && (eff_cnt != `COUNT_ZERO))
      cnt_r <= eff_cnt - `COUNT_ONE;
  end

  assign count_o   = eff_cnt;
  assign tc_zero_o = (eff_cnt == `COUNT_ZERO);

  // Interrupt sense flags.  Each set term is applied after the clear so an
  // event in the clearing cycle is never lost.
  always @*
  begin
    interrupt_sense_reset_nxt = interrupt_sense_reset_r;
    if (wr_take && sel(addr_r, `OFF_INT_SENSE))
      interrupt_sense_reset_nxt = interrupt_sense_reset_r & ~wdata_r;
    if (target_r && !target_i)
      interrupt_sense_reset_nxt[`IS_SERVICE_BIT] = 1'b0;
    interrupt_sense_reset_nxt = interrupt_sense_reset_nxt | int_event_i;
    if (bus_reset_det_i)
      interrupt_sense_reset_nxt[`IS_RESET_BIT] = 1'b1;
    if (arb_lost_i && phase_control_o[`PC_ARB_EN_BIT])
      interrupt_sense_reset_nxt[`IS_CMD_DONE_BIT] = 1'b1;
    if (atn_det_i && target_i && phase_control_o[`PC_ATN_EN_BIT])
      interrupt_sense_reset_nxt[`IS_SERVICE_BIT] = 1'b1;
  end

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      interrupt_sense_reset_r   <= `BYTE_ZERO;
      target_r <= 1'b0;
    end
    else
    begin
      interrupt_sense_reset_r   <= interrupt_sense_reset_nxt;
      target_r <= target_i;
    end
  end

  // Interrupt outputs.  The reset line ignores every mask; the general line
  // stays up as long as any enabled flag remains set.
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_reset_irq_o <= 1'b0;
      general_irq_o   <= 1'b0;
    end
    else
    begin
      bus_reset_irq_o <= interrupt_sense_reset_r[`IS_RESET_BIT];
      general_irq_o   <= controller_control_o[`INT_EN_BIT] &
                         ((|interrupt_sense_reset_r[7:1]) |
                          (interrupt_sense_reset_r[`IS_RESET_BIT] &
                           ~phase_control_o[`PC_RST_MASK_BIT]));
    end
  end

  // Eight-byte FIFO.  Either side may push or pop; the bus side takes the
  // slot when both push in one cycle, so the host byte is then dropped.
  wire h_push = wr_take && sel(addr_r, `OFF_DATA_FIFO);
  wire h_pop  = rd_done && sel(addr_r, `OFF_DATA_FIFO);
  wire push   = (fifo_push_i | h_push) & ~fifo_full_o;
  wire pop    = (fifo_pop_i | h_pop) & ~fifo_empty_o;
  wire [7:0] push_data = fifo_push_i ? fifo_data_i : wdata_r;

  genvar gi;
  generate
    for (gi = 0; gi < `FIFO_DEPTH; gi = gi + 1)
    begin : g_fifo
      // Slot number held at pointer width, so the match below is width-exact.
      localparam [`FIFO_AW-1:0] SLOT = gi;
      // One storage slot, written when the write pointer lands on it.
      always @(posedge sys_clk_i or posedge rst_i)
      begin
        if (rst_i)
          mem_r[gi] <= `BYTE_ZERO;
        else if (push && (wr_ptr_r == SLOT))
          mem_r[gi] <= push_data;
      end
    end
  endgenerate

  // Pointer and level bookkeeping.
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_r <= `PTR_ZERO;
      rd_ptr_r <= `PTR_ZERO;
      level_r  <= `LVL_ZERO;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + `PTR_ONE;
      if (pop)
        rd_ptr_r <= rd_ptr_r + `PTR_ONE;
      if (push && !pop)
        level_r <= level_r + `LVL_ONE;
      else if (pop && !push)
        level_r <= level_r - `LVL_ONE;
    end
  end

  assign fifo_data_o  = mem_r[rd_ptr_r];
  assign fifo_full_o  = (level_r == `LVL_FULL);
  assign fifo_empty_o = (level_r == `LVL_ZERO);

  // Read multiplexer.  Fixed-zero positions are forced here.
  always @*
  begin
    case (addr_i)
      `OFF_BUS_DEVICE_ID: rd_mux = 8'h01 << bus_device_id_o;
      `OFF_CTRL_CONTROL:  rd_mux = controller_control_o;
      `OFF_COMMAND_CODE:  rd_mux = command_code_o;
      `OFF_XFER_MODE:     rd_mux = transfer_mode_o;
      `OFF_INT_SENSE:     rd_mux = interrupt_sense_reset_r;
      `OFF_PHASE_DIAG:    rd_mux = phase_sense_i;
      `OFF_CTRL_STATE:    rd_mux = {initiator_i, target_i, ctrl_status_i,
                                    tc_zero_o, fifo_full_o, fifo_empty_o};
      `OFF_ERROR_FLAGS:   rd_mux = error_flags_i & `ERR_ZERO_MASK;
      `OFF_PHASE_CONTROL:
      begin
        rd_mux = phase_control_o;
        rd_mux[`PC_ZERO_BIT] = 1'b0;
      end
      `OFF_EXT_COUNT:     rd_mux = {(ext_mode ? cnt_r[27:24] : `NIB_ZERO),
                                    mod_count_i};
      `OFF_DATA_FIFO:     rd_mux = fifo_data_o;
      `OFF_TEMP_BYTE:     rd_mux = temp_in_r;
      `OFF_COUNT_HIGH:    rd_mux = cnt_r[23:16];
      `OFF_COUNT_MID:     rd_mux = cnt_r[15:8];
      `OFF_COUNT_LOW:     rd_mux = cnt_r[7:0];
      `OFF_EXT_BUFFER:    rd_mux = ext_buf_i;
      default:            rd_mux = `BYTE_ZERO;
    endcase
  end

  assign rdata_nxt = rd_mux;

  // Read data and host parity.  Data and its parity lag the pins by one
  // clock; the host samples late in its strobe, well after this settles.
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_o            <= `BYTE_ZERO;
      host_parity_out_o <= 1'b1;
    end
    else
    begin
      data_o            <= rdata_nxt;
      host_parity_out_o <= ~^data_i;
    end
  end

  // Drive enables: the parity pin floats whenever the data lines drive.
  assign data_oe_o        = rd_act;
  assign data_par_o       = ~^data_o;
  assign host_parity_oe_o = ~rd_act;

endmodule // reg_map

`default_nettype wire

// ==== test/reg_map_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module reg_map_props (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        cs_n_i,
  input wire logic        rd_n_i,
  input wire logic        wt_n_i,
  input wire logic [7:0]  data_i,
  input wire logic        data_oe_o,
  input wire logic        host_parity_out_o,
  input wire logic        host_parity_oe_o,
  input wire logic        bus_reset_det_i,
  input wire logic        arb_lost_i,
  input wire logic        atn_det_i,
  input wire logic        target_i,
  input wire logic [27:0] count_o,
  input wire logic [7:0]  controller_control_o,
  input wire logic [7:0]  transfer_mode_o,
  input wire logic [7:0]  phase_control_o,
  input wire logic        bus_reset_irq_o,
  input wire logic        general_irq_o
);
  // All checks live in the device clock domain and go quiet during reset.
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic ien = controller_control_o[0];

  // Pin drive and parity; the parity check skips the edge after reset, whose flop is preset.
  property p_oe; data_oe_o == !(cs_n_i | rd_n_i); endproperty
  a_oe: assert property (p_oe) else $error("read drive enable wrong");
  property p_poe; host_parity_oe_o == !data_oe_o; endproperty
  a_poe: assert property (p_poe) else $error("parity pin drives during read");
  property p_dpo; !$past(rst_i) |-> host_parity_out_o == ~^$past(data_i); endproperty
  a_dpo: assert property (p_dpo) else $error("parity output not odd");

  // Interrupt routing, each given a fixed window to show.
  property p_nmi; bus_reset_det_i |-> ##[1:3] bus_reset_irq_o; endproperty
  a_nmi: assert property (p_nmi) else $error("reset interrupt missing");
  property p_grst; bus_reset_det_i && !phase_control_o[4] && ien |-> ##[1:4] general_irq_o;
  endproperty
  a_grst: assert property (p_grst) else $error("unmasked reset not raised");
  property p_arb; arb_lost_i && phase_control_o[6] && ien |-> ##[1:4] general_irq_o; endproperty
  a_arb: assert property (p_arb) else $error("lost arbitration not raised");
  property p_atn;
    atn_det_i && target_i && phase_control_o[5] && ien |-> ##[1:4] general_irq_o;
  endproperty
  a_atn: assert property (p_atn) else $error("attention not raised");

  // With no write and the target role held, nothing may drop a pending request.
  property p_hold;
    general_irq_o && wt_n_i && $past(wt_n_i) && $past(wt_n_i, 2) && $past(wt_n_i, 3)
      && target_i && $past(target_i) |=> general_irq_o;
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped on its own");
  property p_ext; !transfer_mode_o[0] |-> count_o[27:24] == 4'h0; endproperty
  a_ext: assert property (p_ext) else $error("upper count nibble live in short mode");

  c_nmi: cover property (bus_reset_irq_o);
  c_irq: cover property ($rose(general_irq_o));
  c_ext: cover property (transfer_mode_o[0]);
endmodule // reg_map_props

bind reg_map reg_map_props u_props (.*);
`default_nettype wire

// ==== test/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic       cs_n_o,
  output var  logic       rd_n_o,
  output var  logic       wt_n_o,
  output var  logic [3:0] addr_o,
  output var  logic [7:0] wdata_o
);
  // Bus idle at time zero.
  initial
  begin
    {cs_n_o, rd_n_o, wt_n_o} = 3'h7;
    addr_o = 4'h0;
    wdata_o = 8'h00;
  end

  // Strobe low one clock, then lifted while select, address and data still hold.
  // Callers set the count nibble first, leave mode alone mid-transfer, fill spare bits freely.
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {cs_n_o, wt_n_o} <= 2'h0;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wt_n_o <= 1'b1;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    wdata_o <= ~d; // A released bus shows the inverse, so stale data cannot pass.
    @(posedge clk_i);
    #1;
  endtask

  // Data is taken at the edge that also ends the strobe.
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    {cs_n_o, rd_n_o} <= 2'h0;
    addr_o <= a;
    repeat (2) @(posedge clk_i);
    d = rdata_i;
    {cs_n_o, rd_n_o} <= 2'h3;
    @(posedge clk_i);
    #1;
  endtask
endmodule // host_model
`default_nettype wire

// ==== test/reg_map_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module reg_map_tb;
  // Design pins; bus pins come from the host model.
  logic sys_clk_i, rst_i, bus_reset_det_i, arb_lost_i, atn_det_i, initiator_i, target_i;
  logic temp_load_i, fifo_push_i, fifo_pop_i, tc_dec_i;
  logic [7:0] int_event_i, phase_sense_i, error_flags_i, temp_in_i, fifo_data_i, ext_buf_i;
  logic [3:0] mod_count_i;
  logic [2:0] ctrl_status_i;
  wire logic cs_n_i, rd_n_i, wt_n_i, data_oe_o, data_par_o, host_parity_out_o, host_parity_oe_o;
  wire logic fifo_full_o, fifo_empty_o, tc_zero_o, cmd_issue_o, ext_buf_wr_o;
  wire logic bus_reset_irq_o, general_irq_o;
  wire logic [7:0] data_i, data_o, temp_out_o, fifo_data_o, controller_control_o, command_code_o;
  wire logic [7:0] transfer_mode_o, phase_control_o, diag_control_o, ext_buf_o;
  wire logic [3:0] addr_i;
  wire logic [2:0] bus_device_id_o;
  wire logic [27:0] count_o;
  int fail_count = 0;
  int n_compared = 0;
  int n_cmd = 0;
  int n_xbw = 0;
  logic [7:0] rv;
  logic [3:0] ra [7] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'hC, 4'hD, 4'hE};
  logic [7:0] rm [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hF7, 8'hFF, 8'hFF, 8'hFF};

  reg_map uut (.*);
  host_model host (.clk_i(sys_clk_i), .rdata_i(data_o), .cs_n_o(cs_n_i), .rd_n_o(rd_n_i),
                   .wt_n_o(wt_n_i), .addr_o(addr_i), .wdata_o(data_i));

  // Device clock, 5 ns period.
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // Cycles of each write pulse; a pulse that stands longer than one clock shows up here.
  always @(posedge sys_clk_i)
  begin
    if (cmd_issue_o)
      n_cmd <= n_cmd + 1;
    if (ext_buf_wr_o)
      n_xbw <= n_xbw + 1;
  end

  task chk(input logic [27:0] act, input logic [27:0] exp);
    n_compared++;
    if (act !== exp)
      $display("Error at %0t: got %0h expected %0h", $time, act, exp);
    if (act !== exp)
      fail_count++;
  endtask

  task byt(input logic [7:0] act, input logic [7:0] exp);
    chk({20'h00000, act}, {20'h00000, exp});
  endtask

  task flag(input logic act, input logic exp);
    chk({{27{1'b0}}, act}, {{27{1'b0}}, exp});
  endtask

  task rdc(input logic [3:0] a, input logic [7:0] e);
    host.rd(a, rv);
    byt(rv, e);
    flag(data_par_o, ~^rv);
  endtask

  // One-clock pulse on bus reset, lost arbitration, attention; then time to settle.
  task ev(input logic [2:0] s);
    @(posedge sys_clk_i);
    {bus_reset_det_i, arb_lost_i, atn_det_i} <= s;
    @(posedge sys_clk_i);
    {bus_reset_det_i, arb_lost_i, atn_det_i} <= 3'h0;
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask

  task tend(input string s);
    $display("Test %s finished", s);
  endtask

  task conclude;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence; bus-side push and the int_event_i inputs stay idle.
  initial
  begin
    rst_i = 1'b1;
    {bus_reset_det_i, arb_lost_i, atn_det_i, initiator_i, target_i} = 5'h00;
    {temp_load_i, fifo_push_i, fifo_pop_i, tc_dec_i} = 4'h0;
    {int_event_i, phase_sense_i, error_flags_i} = 24'h00A6FF;
    {temp_in_i, fifo_data_i, ext_buf_i} = 24'hC30096;
    mod_count_i = 4'h3;
    ctrl_status_i = 3'h5;
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      host.wr(ra[i], 8'h5A);
      rdc(ra[i], 8'h5A & rm[i]);
    end
    chk(count_o, 28'h05A5A5A);
    host.wr(4'h0, 8'hFD);
    rdc(4'h0, 8'h20);
    byt({5'h00, bus_device_id_o}, 8'h05);
    host.wr(4'h5, 8'h3C);
    rdc(4'h5, 8'hA6);
    byt(diag_control_o, 8'h3C);
    host.wr(4'h6, 8'h00);
    host.wr(4'h7, 8'h00);
    rdc(4'h6, 8'h29);
    rdc(4'h7, 8'hCF);
    tend("map");
    host.wr(4'h9, 8'hF0);
    rdc(4'h9, 8'h03);
    host.wr(4'h3, 8'h01);
    rdc(4'h9, 8'hF3);
    chk(count_o, 28'hF5A5A5A);
    @(posedge sys_clk_i);
    tc_dec_i <= 1'b1;
    @(posedge sys_clk_i);
    tc_dec_i <= 1'b0;
    #1;
    chk(count_o, 28'hF5A5A59);
    host.wr(4'h3, 8'h00);
    chk(count_o, 28'h05A5A59);
    @(posedge sys_clk_i);
    temp_load_i <= 1'b1;
    @(posedge sys_clk_i);
    temp_load_i <= 1'b0;
    rdc(4'hB, 8'hC3);
    host.wr(4'hB, 8'h3C);
    byt(temp_out_o, 8'h3C);
    rdc(4'hF, 8'h96);
    host.wr(4'hF, 8'h69);
    byt(ext_buf_o, 8'h69);
    byt(n_xbw[7:0], 8'h01);
    byt(n_cmd[7:0], 8'h01);
    tend("count");
    for (int i = 0; i < 9; i++)
      host.wr(4'hA, 8'h10 + i[7:0]);
    flag(fifo_full_o, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      byt(fifo_data_o, 8'h10 + i[7:0]);
      @(posedge sys_clk_i);
      fifo_pop_i <= 1'b1;
      @(posedge sys_clk_i);
      fifo_pop_i <= 1'b0;
      #1;
    end
    flag(fifo_empty_o, 1'b1);
    tend("fifo");
    host.wr(4'h1, 8'h01);
    host.wr(4'h8, 8'h00);
    ev(3'h4);
    byt({6'h00, bus_reset_irq_o, general_irq_o}, 8'h03);
    host.wr(4'h4, 8'h01);
    byt({6'h00, bus_reset_irq_o, general_irq_o}, 8'h00);
    host.wr(4'h8, 8'h10);
    ev(3'h4);
    byt({6'h00, bus_reset_irq_o, general_irq_o}, 8'h02);
    host.wr(4'h4, 8'h01);
    host.wr(4'h8, 8'h40);
    ev(3'h2);
    flag(general_irq_o, 1'b1);
    rdc(4'h6, 8'h29);
    @(posedge sys_clk_i);
    initiator_i <= 1'b1;
    rdc(4'h6, 8'hA9);
    host.wr(4'h4, 8'h10);
    host.wr(4'h8, 8'h20);
    @(posedge sys_clk_i);
    target_i <= 1'b1;
    ev(3'h1);
    flag(general_irq_o, 1'b1);
    @(posedge sys_clk_i);
    target_i <= 1'b0;
    ev(3'h0);
    flag(general_irq_o, 1'b0);
    @(posedge sys_clk_i);
    target_i <= 1'b1;
    ev(3'h1);
    host.wr(4'h4, 8'h08);
    flag(general_irq_o, 1'b0);
    tend("irq");
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rdc(4'h1, 8'h00);
    chk(count_o, 28'h0000000);
    tend("reset");
    conclude();
  end
endmodule // reg_map_tb
`default_nettype wire
